/* verilog/swp_sector_protect.sv */
// Purpose: sector write protection controller with lock and password
// Assumes: commands are one-cycle strobes synchronous to SYS_CLK
// Notes:   SYS_RST is power-on or hardware reset; SW_RST only resets status and the overlay flag
`timescale 1ns/1ps
module swp_sector_protect #(
  parameter int unsigned     SECTORS        = swp_pkg::SECTORS,
  parameter int unsigned     SECT_W         = $clog2(SECTORS),
  parameter longint unsigned WORD_PROG_CYC  = swp_pkg::WORD_PROG_CYC,
  parameter longint unsigned SECT_ERASE_CYC = swp_pkg::SECT_ERASE_CYC,
  parameter logic [63:0]     PASSWORD_INIT  = 64'hFFFF_FFFF_FFFF_FFFF
) (
  input  wire logic                      SYS_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic                      SW_RST,
  input  wire logic                      CMD_VALID,
  input  wire swp_pkg::swp_cmd_type      CMD_CODE,
  input  wire logic [SECT_W-1:0]         CMD_SECTOR,
  input  wire logic [swp_pkg::PWD_W-1:0] CMD_PASSWORD,
  input  wire logic [1:0]                CMD_CFG_BITS,
  input  wire logic                      ACCESS_REQ,
  input  wire logic [SECT_W-1:0]         ACCESS_SECTOR,
  input  wire logic                      STATUS_READ,
  input  wire logic [SECT_W-1:0]         STATUS_SECTOR,
  output logic                           ACCESS_GRANT,
  output logic                           ACCESS_DENY,
  output logic                           LOCK_BIT,
  output logic [1:0]                     PROT_MODE,
  output logic                           OVERLAY_ACTIVE,
  output logic                           STATUS_VALID,
  output logic                           STATUS_PBIT,
  output logic [swp_pkg::STAT_W-1:0]     STATUS_REG,
  output logic [SECTORS-1:0]             SECTOR_WRITABLE
);
  localparam int unsigned CW = 32;

  ////////////////////////////////////////////////////////////////////////////
  // one-time-programmable mode field and hidden password
  logic [1:0]                mode_q = swp_pkg::MODE_RESET;
  logic [swp_pkg::PWD_W-1:0] pwd_q  = PASSWORD_INIT;
  logic                      lock_q;
  logic                      ovl_q;
  logic [swp_pkg::STAT_W-1:0] stat_q;
  logic                      op_erase_q;
  logic [SECT_W-1:0]         op_sector_q;
  logic                      grant_q;
  logic                      deny_q;
  logic                      sval_q;
  logic                      spbit_q;
  logic [SECTORS-1:0]        wr_q;

  wire cmd   = CMD_VALID;
  wire is_pw = (mode_q == swp_pkg::MODE_PASSWORD);
  wire frozen = (mode_q == swp_pkg::MODE_PASSWORD) || (mode_q == swp_pkg::MODE_PERSIST);
  wire busy;
  wire done;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  wire c_lclr  = cmd && (CMD_CODE == swp_pkg::CMD_LOCK_CLEAR);
  wire c_unl   = cmd && (CMD_CODE == swp_pkg::CMD_UNLOCK);
  wire c_pprog = cmd && (CMD_CODE == swp_pkg::CMD_PBIT_PROG);
  wire c_perase = cmd && (CMD_CODE == swp_pkg::CMD_PBIT_ERASE);
  wire c_dset  = cmd && (CMD_CODE == swp_pkg::CMD_DBIT_SET);
  wire c_dclr  = cmd && (CMD_CODE == swp_pkg::CMD_DBIT_CLEAR);
  wire c_cfg   = cmd && (CMD_CODE == swp_pkg::CMD_CFG_PROG);
  wire c_stclr = cmd && (CMD_CODE == swp_pkg::CMD_STATUS_CLEAR);

  wire p_req     = (c_pprog || c_perase) && !busy;
  wire p_allowed = p_req && lock_q;
  wire p_refused = p_req && !lock_q;
  wire pw_match  = (CMD_PASSWORD == pwd_q);
  wire cfg_both  = (CMD_CFG_BITS == 2'h3);
  wire cfg_fail  = c_cfg && !busy && (cfg_both || frozen);
  wire cfg_ok    = c_cfg && !busy && !cfg_fail && (CMD_CFG_BITS != 2'h0);

  wire [CW-1:0] op_cycles = c_perase ? CW'(SECT_ERASE_CYC) : CW'(WORD_PROG_CYC);
  wire          t_start   = p_allowed || cfg_ok;

  ////////////////////////////////////////////////////////////////////////////
  // busy timer: word time for single program, sector time for erase
  swp_timer #(.CW(CW)) u_timer (
    .clk    (SYS_CLK),
    .rst    (SYS_RST),
    .start  (t_start),
    .cycles (op_cycles),
    .busy   (busy),
    .done   (done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sector cells
  wire [SECTORS-1:0] pbits;
  wire [SECTORS-1:0] dbits;
  wire [SECTORS-1:0] wr;
  logic              op_cfg_q;

  genvar g;
  generate
    for (g = 0; g < SECTORS; g++) begin : g_sect
      wire hit_prog  = done && !op_cfg_q && !op_erase_q && (op_sector_q == SECT_W'(g));
      wire hit_erase = done && !op_cfg_q && op_erase_q;
      swp_sector_cell u_cell (
        .clk        (SYS_CLK),
        .hw_rst     (SYS_RST),
        .pbit_prog  (hit_prog),
        .pbit_erase (hit_erase),
        .dbit_set   (c_dset && (CMD_SECTOR == SECT_W'(g))),
        .dbit_clear (c_dclr && (CMD_SECTOR == SECT_W'(g))),
        .pbit       (pbits[g]),
        .dbit       (dbits[g]),
        .writable   (wr[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pending operation bookkeeping; config programs on completion
  logic [1:0] cfg_pend_q;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      op_erase_q  <= 1'b0;
      op_sector_q <= '0;
      op_cfg_q    <= 1'b0;
      cfg_pend_q  <= 2'h0;
    end else if (t_start) begin
      op_erase_q  <= c_perase;
      op_sector_q <= CMD_SECTOR;
      op_cfg_q    <= cfg_ok;
      cfg_pend_q  <= CMD_CFG_BITS;
    end
  end

  // otp field: programming clears one bit, no reset touches it
  always_ff @(posedge SYS_CLK) begin
    if (done && op_cfg_q) begin
      mode_q <= mode_q & ~cfg_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the single volatile lock bit
  wire lock_set = c_unl && is_pw && pw_match;

  // reset value follows the otp mode; software reset is not wired here
  // at all, so the lock survives it
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      lock_q <= !is_pw;
    end else if (c_lclr) begin
      lock_q <= 1'b0;
    end else if (lock_set) begin
      lock_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register, overlay, access checks
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || SW_RST) begin
      stat_q <= 8'h80;
      ovl_q  <= 1'b0;
    end else begin
      stat_q[swp_pkg::STAT_READY] <= !(t_start || (busy && !done));
      if (p_refused || cfg_fail) begin
        stat_q[swp_pkg::STAT_PROG_ERR] <= 1'b1;
        stat_q[swp_pkg::STAT_PROT_ERR] <= 1'b1;
      end else if (c_stclr) begin
        stat_q[swp_pkg::STAT_PROG_ERR] <= 1'b0;
        stat_q[swp_pkg::STAT_PROT_ERR] <= 1'b0;
      end
      if (cmd && CMD_CODE == swp_pkg::CMD_OVL_ENTER) begin
        ovl_q <= 1'b1;
      end else if (cmd && CMD_CODE == swp_pkg::CMD_OVL_EXIT) begin
        ovl_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      grant_q <= 1'b0;
      deny_q  <= 1'b0;
      sval_q  <= 1'b0;
      spbit_q <= 1'b1;
      wr_q    <= '1;
    end else begin
      grant_q <= ACCESS_REQ && wr[ACCESS_SECTOR];
      deny_q  <= ACCESS_REQ && !wr[ACCESS_SECTOR];
      sval_q  <= STATUS_READ && ovl_q;
      spbit_q <= pbits[STATUS_SECTOR];
      wr_q    <= wr;
    end
  end

  assign ACCESS_GRANT    = grant_q;
  assign ACCESS_DENY     = deny_q;
  assign LOCK_BIT        = lock_q;
  assign PROT_MODE       = mode_q;
  assign OVERLAY_ACTIVE  = ovl_q;
  assign STATUS_VALID    = sval_q;
  assign STATUS_PBIT     = spbit_q;
  assign STATUS_REG      = stat_q;
  assign SECTOR_WRITABLE = wr_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_refuse;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (c_pprog && !busy && !LOCK_BIT) |=> STATUS_REG[swp_pkg::STAT_PROG_ERR];
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked program not reported");

  property p_clear_lock;
    @(posedge SYS_CLK) disable iff (SYS_RST) c_lclr |=> !LOCK_BIT;
  endproperty
  a_clear_lock: assert property (p_clear_lock) else $error("lock clear ignored");

  property p_no_relock;
    @(posedge SYS_CLK) disable iff (SYS_RST) (!is_pw && !LOCK_BIT) |=> !LOCK_BIT;
  endproperty
  a_no_relock: assert property (p_no_relock) else $error("persistent lock reset");

  property p_grant;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (ACCESS_REQ && (!pbits[ACCESS_SECTOR] || !dbits[ACCESS_SECTOR])) |=> ACCESS_DENY;
  endproperty
  a_grant: assert property (p_grant) else $error("protected sector granted");

  property p_dset;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      c_dset |=> !dbits[$past(CMD_SECTOR)];
  endproperty
  a_dset: assert property (p_dset) else $error("dynamic set failed");

  property p_cfg_both;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (c_cfg && !busy && CMD_CFG_BITS == 2'h3) |=> STATUS_REG[swp_pkg::STAT_PROT_ERR];
  endproperty
  a_cfg_both: assert property (p_cfg_both) else $error("double mode lock not failed");

  property p_unlock;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (c_unl && is_pw && !pw_match && !LOCK_BIT && !c_lclr) |=> !LOCK_BIT;
  endproperty
  a_unlock: assert property (p_unlock) else $error("wrong password unlocked");

  property p_busy;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      p_allowed |=> !STATUS_REG[swp_pkg::STAT_READY];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");

  property p_rst_lock;
    @(posedge SYS_CLK) SYS_RST |=> (LOCK_BIT != $past(is_pw));
  endproperty
  a_rst_lock: assert property (p_rst_lock) else $error("bad lock after reset");

  property p_sw_keep;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (SW_RST && !c_lclr && !lock_set) |=> $stable(LOCK_BIT);
  endproperty
  a_sw_keep: assert property (p_sw_keep) else $error("soft reset moved lock");

  property p_rise_src;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      $rose(LOCK_BIT) |-> ($past(lock_set) || $past(SYS_RST));
  endproperty
  a_rise_src: assert property (p_rise_src) else $error("lock set without unlock");

  property p_persist_unl;
    @(posedge SYS_CLK) disable iff (SYS_RST) (c_unl && !is_pw) |=> $stable(LOCK_BIT);
  endproperty
  a_persist_unl: assert property (p_persist_unl) else $error("persistent unlock");

  property p_unlock_ok;
    @(posedge SYS_CLK) disable iff (SYS_RST) (c_unl && is_pw && pw_match) |=> LOCK_BIT;
  endproperty
  a_unlock_ok: assert property (p_unlock_ok) else $error("right password refused");

  property p_erase_refuse;
    @(posedge SYS_CLK) disable iff (SYS_RST || SW_RST)
      (c_perase && !busy && !LOCK_BIT) |=> (STATUS_REG[swp_pkg::STAT_PROG_ERR]
        && STATUS_REG[swp_pkg::STAT_PROT_ERR] && STATUS_REG[swp_pkg::STAT_READY]);
  endproperty
  a_erase_refuse: assert property (p_erase_refuse) else $error("locked erase ran");

  property p_no_start;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      ((c_pprog || c_perase) && !busy && !LOCK_BIT) |=> !busy;
  endproperty
  a_no_start: assert property (p_no_start) else $error("locked operation started");

  property p_dclr;
    @(posedge SYS_CLK) disable iff (SYS_RST) c_dclr |=> dbits[$past(CMD_SECTOR)];
  endproperty
  a_dclr: assert property (p_dclr) else $error("dynamic clear failed");

  property p_hw_dyn;
    @(posedge SYS_CLK) SYS_RST |=> (&dbits);
  endproperty
  a_hw_dyn: assert property (p_hw_dyn) else $error("dynamic bits kept by reset");

  property p_pbit_keep;
    @(posedge SYS_CLK) !done |=> $stable(pbits);
  endproperty
  a_pbit_keep: assert property (p_pbit_keep) else $error("persistent bits moved");

  property p_erase_all;
    @(posedge SYS_CLK) (done && !op_cfg_q && op_erase_q) |=> (&pbits);
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("group erase incomplete");

  property p_ovl_read;
    @(posedge SYS_CLK) disable iff (SYS_RST) (STATUS_READ && OVERLAY_ACTIVE)
      |=> (STATUS_VALID && (STATUS_PBIT == $past(pbits[STATUS_SECTOR])));
  endproperty
  a_ovl_read: assert property (p_ovl_read) else $error("overlay read wrong");

  property p_ovl_off;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (STATUS_READ && !OVERLAY_ACTIVE) |=> !STATUS_VALID;
  endproperty
  a_ovl_off: assert property (p_ovl_off) else $error("read outside overlay");

  property p_frozen;
    @(posedge SYS_CLK) frozen |=> $stable(PROT_MODE);
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen mode field changed");

  property p_frozen_fail;
    @(posedge SYS_CLK) disable iff (SYS_RST || SW_RST)
      (c_cfg && !busy && frozen) |=> (STATUS_REG[swp_pkg::STAT_PROG_ERR]
        && STATUS_REG[swp_pkg::STAT_PROT_ERR]);
  endproperty
  a_frozen_fail: assert property (p_frozen_fail) else $error("frozen field taken");

  property p_cfg_busy;
    @(posedge SYS_CLK) disable iff (SYS_RST || SW_RST)
      (c_cfg && !busy && !frozen && (CMD_CFG_BITS inside {2'h1, 2'h2}))
        |=> !STATUS_REG[swp_pkg::STAT_READY];
  endproperty
  a_cfg_busy: assert property (p_cfg_busy) else $error("mode program not busy");

  property p_ready_back;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (done && !t_start) |=> STATUS_REG[swp_pkg::STAT_READY];
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready not restored");

  property p_grant_ok;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (ACCESS_REQ && pbits[ACCESS_SECTOR] && dbits[ACCESS_SECTOR])
        |=> (ACCESS_GRANT && !ACCESS_DENY);
  endproperty
  a_grant_ok: assert property (p_grant_ok) else $error("open sector denied");
endmodule

/* inc/swp_pkg.sv */
// Purpose: shared constants for the sector write protection block
// Assumes: one clock, synchronous active-high reset
// Notes:   times are in microseconds, cycle counts derived from the clock rate
// Contract
// - sector program/erase blocked when persistent or dynamic bit is zero
// - lock bit zero refuses any program or erase of persistent bits
// - persistent mode: lock bit set to one on power-on or hardware reset
// - software reset leaves the lock bit untouched in both modes
// - persistent mode: no command sets the lock once cleared
// - password mode: lock bit cleared to zero on power-on or hardware reset
// - password mode: unlock sets lock only when 64-bit candidate matches stored password
// - password mode: only unlock sets lock; lock-clear may zero it anytime
// - lock-clear command zeroes lock; host issues it after persistent bits configured
// - exactly one volatile lock bit; zero locked, one changeable
// - mode choice comes from one-time-programmable configuration bits
// - persistent bits delivered erased, all sectors unprotected
// - persistent bits programmed singly, erased only all together
// - program takes word time, erase takes sector time; busy visible meanwhile
// - persistent program/erase with lock zero aborts and reports failure
// - overlay active: status read returns persistent bit of addressed sector
// - dynamic set command writes zero, clear writes one, repeatedly
// - hardware reset restores dynamic bits unprotected; persistent bits kept
// - dynamic bits changeable regardless of lock bit
// - mode field: 01 password, 10 persistent, 11 temporary persistent, 00 illegal
// - programming both mode-lock bits at once aborts, setting status bits four and one
package swp_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned WORD_PROG_US    = 500;
  localparam int unsigned SECT_ERASE_US   = 930000;
  localparam int unsigned WORD_PROG_CYC   = WORD_PROG_US * (CLK_HZ / 1000000);
  localparam longint unsigned SECT_ERASE_CYC = 64'(SECT_ERASE_US) * (CLK_HZ / 1000000);
  localparam int unsigned PWD_W           = 64;
  localparam int unsigned SECTORS         = 512;
  localparam int unsigned STAT_W          = 8;
  localparam int unsigned STAT_READY      = 7;
  localparam int unsigned STAT_PROG_ERR   = 4;
  localparam int unsigned STAT_PROT_ERR   = 1;
  localparam logic [1:0]  MODE_PASSWORD   = 2'h1;
  localparam logic [1:0]  MODE_PERSIST    = 2'h2;
  localparam logic [1:0]  MODE_TEMP       = 2'h3;
  localparam logic [1:0]  MODE_ILLEGAL    = 2'h0;
  localparam logic [1:0]  MODE_RESET      = 2'h3;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_LOCK_CLEAR, CMD_UNLOCK, CMD_PBIT_PROG, CMD_PBIT_ERASE,
    CMD_DBIT_SET, CMD_DBIT_CLEAR, CMD_CFG_PROG, CMD_OVL_ENTER, CMD_OVL_EXIT,
    CMD_STATUS_CLEAR
  } swp_cmd_type;
endpackage

/* verilog/swp_timer.sv */
// Purpose: busy timer for persistent bit operations
// Assumes: start is a one-cycle pulse while idle
// Notes:   done pulses one cycle after the count runs out
`timescale 1ns/1ps
module swp_timer #(
  parameter int unsigned CW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [CW-1:0] cycles,
  output logic               busy,
  output logic               done
);
  logic [CW-1:0] cnt_q;
  logic          busy_q;
  logic          done_q;
  wire           last = busy_q && (cnt_q <= CW'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= last;
      if (start && !busy_q) begin
        cnt_q  <= cycles;
        busy_q <= 1'b1;
      end else if (last) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule

/* verilog/swp_sector_cell.sv */
// Purpose: one sector's persistent and dynamic protection bits
// Assumes: commands arrive already qualified by the controller
// Notes:   persistent bit survives hardware reset, dynamic bit does not
`timescale 1ns/1ps
module swp_sector_cell (
  input  wire logic clk,
  input  wire logic hw_rst,
  input  wire logic pbit_prog,
  input  wire logic pbit_erase,
  input  wire logic dbit_set,
  input  wire logic dbit_clear,
  output logic      pbit,
  output logic      dbit,
  output logic      writable
);
  // non-volatile: reset never touches it; starts erased
  logic pbit_q = 1'b1;
  logic dbit_q;

  always_ff @(posedge clk) begin
    if (pbit_erase) begin
      pbit_q <= 1'b1;
    end else if (pbit_prog) begin
      pbit_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      dbit_q <= 1'b1;
    end else if (dbit_set) begin
      dbit_q <= 1'b0;
    end else if (dbit_clear) begin
      dbit_q <= 1'b1;
    end
  end

  assign pbit     = pbit_q;
  assign dbit     = dbit_q;
  assign writable = pbit_q & dbit_q;
endmodule

/* bench/swp_host_model.sv */
// Purpose: host controller model that issues protection commands
// Assumes: bench raises req one cycle ahead of the command strobe
// Notes:   released sector and key lines toggle so stale values never pass
`timescale 1ns/1ps
module swp_host_model #(
  parameter int unsigned SECT_W = 3
) (
  input  wire logic                 clk,
  input  wire logic                 req,
  input  wire swp_pkg::swp_cmd_type code,
  input  wire logic [SECT_W-1:0]    sector,
  input  wire logic [63:0]          pwd,
  input  wire logic [1:0]           cfg,
  output logic                      cmd_valid,
  output swp_pkg::swp_cmd_type      cmd_code,
  output logic [SECT_W-1:0]         cmd_sector,
  output logic [63:0]               cmd_pwd,
  output logic [1:0]                cmd_cfg
);
  initial begin
    cmd_valid = 1'h0;
    cmd_code = swp_pkg::CMD_NONE;
    cmd_sector = '0;
    cmd_pwd = 64'h0;
    cmd_cfg = 2'h0;
  end
  ////////////////////////////////////////////////////////////////
  // one strobe per request; every code, lock clear included, is passed on whenever req is high
  always @(posedge clk) begin
    cmd_valid <= req;
    cmd_code <= req ? code : swp_pkg::CMD_NONE;
    cmd_sector <= req ? sector : ~cmd_sector;
    cmd_pwd <= req ? pwd : ~cmd_pwd;
    cmd_cfg <= req ? cfg : ~cmd_cfg;
  end
endmodule

/* bench/test_sector_write_protection.sv */
// Purpose: self-checking bench for the sector protection controller
// Assumes: short program and erase counts, eight sectors
// Notes:   mode bits are one-time, so the mode change comes last
`timescale 1ns/1ps
module test_sector_write_protection;
  localparam logic [63:0] KEY = 64'h5A5A_0F0F_C3C3_9696;
  logic                 SYS_CLK, SYS_RST, SW_RST, REQ, CMD_VALID;
  logic                 ACCESS_REQ, STATUS_READ, ACCESS_GRANT, ACCESS_DENY;
  logic                 LOCK_BIT, OVERLAY_ACTIVE, STATUS_VALID, STATUS_PBIT;
  swp_pkg::swp_cmd_type CODE, CMD_CODE;
  logic [2:0]           SECT, CMD_SECTOR, ACCESS_SECTOR, STATUS_SECTOR;
  logic [63:0]          PWD, CMD_PASSWORD;
  logic [1:0]           CFG, CMD_CFG_BITS, PROT_MODE;
  logic [7:0]           STATUS_REG, SECTOR_WRITABLE;
  int                   err_count = 0;
  int                   compares = 0;
  swp_host_model #(.SECT_W(3)) host (.clk(SYS_CLK), .req(REQ), .code(CODE),
    .sector(SECT), .pwd(PWD), .cfg(CFG), .cmd_valid(CMD_VALID), .cmd_code(CMD_CODE),
    .cmd_sector(CMD_SECTOR), .cmd_pwd(CMD_PASSWORD), .cmd_cfg(CMD_CFG_BITS));
  swp_sector_protect #(.SECTORS(8), .SECT_W(3), .WORD_PROG_CYC(5), .SECT_ERASE_CYC(10),
    .PASSWORD_INIT(KEY)) uut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SW_RST(SW_RST),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_SECTOR(CMD_SECTOR),
    .CMD_PASSWORD(CMD_PASSWORD), .CMD_CFG_BITS(CMD_CFG_BITS), .ACCESS_REQ(ACCESS_REQ),
    .ACCESS_SECTOR(ACCESS_SECTOR), .STATUS_READ(STATUS_READ),
    .STATUS_SECTOR(STATUS_SECTOR), .ACCESS_GRANT(ACCESS_GRANT),
    .ACCESS_DENY(ACCESS_DENY), .LOCK_BIT(LOCK_BIT), .PROT_MODE(PROT_MODE),
    .OVERLAY_ACTIVE(OVERLAY_ACTIVE), .STATUS_VALID(STATUS_VALID),
    .STATUS_PBIT(STATUS_PBIT), .STATUS_REG(STATUS_REG),
    .SECTOR_WRITABLE(SECTOR_WRITABLE));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // answer is read two edges after the strobe, busy counts are longer
  task automatic cmd(input swp_pkg::swp_cmd_type c, input logic [2:0] s = 3'h0,
                     input logic [63:0] p = 64'h0, input logic [1:0] f = 2'h0);
    @(posedge SYS_CLK);
    REQ <= 1'h1;
    CODE <= c;
    SECT <= s;
    PWD <= p;
    CFG <= f;
    @(posedge SYS_CLK);
    REQ <= 1'h0;
    repeat (2) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic acc(input logic [2:0] s, input logic [1:0] exp);
    @(posedge SYS_CLK);
    ACCESS_REQ <= 1'h1;
    ACCESS_SECTOR <= s;
    @(posedge SYS_CLK);
    ACCESS_REQ <= 1'h0;
    ACCESS_SECTOR <= ~s;
    #1;
    chk({6'h0, ACCESS_GRANT, ACCESS_DENY}, {6'h0, exp}, "access answer");
  endtask
  task automatic stat(input logic [2:0] s, input logic [1:0] exp);
    @(posedge SYS_CLK);
    STATUS_READ <= 1'h1;
    STATUS_SECTOR <= s;
    @(posedge SYS_CLK);
    STATUS_READ <= 1'h0;
    STATUS_SECTOR <= ~s;
    #1;
    chk({6'h0, STATUS_VALID, STATUS_PBIT}, {6'h0, exp}, "overlay read");
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (STATUS_REG[7] !== 1'h1 && n < 100) begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    // writable map trails the cells by one edge
    @(posedge SYS_CLK);
    #1;
    if (n >= 100) begin
      err_count++;
      $display("[ERR] %0t ready never returned", $time);
      results();
    end
  endtask
  task automatic hw_reset();
    @(posedge SYS_CLK);
    SYS_RST <= 1'h1;
    repeat (5) @(posedge SYS_CLK);
    SYS_RST <= 1'h0;
    @(posedge SYS_CLK);
    #1;
  endtask
  task automatic sw_reset();
    @(posedge SYS_CLK);
    SW_RST <= 1'h1;
    @(posedge SYS_CLK);
    SW_RST <= 1'h0;
    repeat (2) @(posedge SYS_CLK);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK = 1'h0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    {SYS_RST, SW_RST, REQ, ACCESS_REQ, STATUS_READ} = 5'h10;
    CODE = swp_pkg::CMD_NONE;
    {SECT, PWD, CFG} = '0;
    {ACCESS_SECTOR, STATUS_SECTOR} = 6'h0;
    hw_reset();
    chk(LOCK_BIT, 1'h1, "lock after reset");
    chk(PROT_MODE, swp_pkg::MODE_TEMP, "factory mode");
    chk(STATUS_REG, 8'h80, "status after reset");
    chk(SECTOR_WRITABLE, 8'hFF, "sectors unprotected");
    acc(3'h2, 2'h2);
    cmd(swp_pkg::CMD_DBIT_SET, 3'h2);
    acc(3'h2, 2'h1);
    cmd(swp_pkg::CMD_DBIT_CLEAR, 3'h2);
    acc(3'h2, 2'h2);
    cmd(swp_pkg::CMD_DBIT_SET, 3'h3);
    cmd(swp_pkg::CMD_PBIT_PROG, 3'h5);
    chk(STATUS_REG[7], 1'h0, "busy during program");
    wait_ready();
    chk(SECTOR_WRITABLE, 8'hD7, "single bit programmed");
    cmd(swp_pkg::CMD_OVL_ENTER);
    chk(OVERLAY_ACTIVE, 1'h1, "overlay entered");
    stat(3'h5, 2'h2);
    stat(3'h4, 2'h3);
    cmd(swp_pkg::CMD_OVL_EXIT);
    chk(OVERLAY_ACTIVE, 1'h0, "overlay left");
    stat(3'h5, 2'h0);
    sw_reset();
    chk(LOCK_BIT, 1'h1, "lock after soft reset");
    cmd(swp_pkg::CMD_LOCK_CLEAR);
    chk(LOCK_BIT, 1'h0, "lock cleared");
    cmd(swp_pkg::CMD_UNLOCK, 3'h0, KEY);
    chk(LOCK_BIT, 1'h0, "no set in persistent mode");
    cmd(swp_pkg::CMD_DBIT_SET, 3'h4);
    chk(SECTOR_WRITABLE, 8'hC7, "dynamic bit while locked");
    cmd(swp_pkg::CMD_DBIT_CLEAR, 3'h4);
    cmd(swp_pkg::CMD_PBIT_ERASE);
    chk(STATUS_REG, 8'h92, "erase refused");
    cmd(swp_pkg::CMD_PBIT_PROG, 3'h0);
    wait_ready();
    chk(SECTOR_WRITABLE, 8'hD7, "program refused");
    cmd(swp_pkg::CMD_STATUS_CLEAR);
    chk(STATUS_REG, 8'h80, "status cleared");
    hw_reset();
    chk(LOCK_BIT, 1'h1, "lock back after reset");
    chk(SECTOR_WRITABLE, 8'hDF, "dynamic reset, persistent kept");
    cmd(swp_pkg::CMD_PBIT_ERASE);
    chk(STATUS_REG[7], 1'h0, "busy during erase");
    wait_ready();
    chk(SECTOR_WRITABLE, 8'hFF, "group erase");
    cmd(swp_pkg::CMD_CFG_PROG, 3'h0, 64'h0, 2'h3);
    wait_ready();
    chk(STATUS_REG, 8'h92, "both mode bits refused");
    chk(PROT_MODE, swp_pkg::MODE_TEMP, "mode unchanged");
    cmd(swp_pkg::CMD_STATUS_CLEAR);
    cmd(swp_pkg::CMD_CFG_PROG, 3'h0, 64'h0, 2'h2);
    wait_ready();
    chk(PROT_MODE, swp_pkg::MODE_PASSWORD, "password mode");
    cmd(swp_pkg::CMD_CFG_PROG, 3'h0, 64'h0, 2'h1);
    wait_ready();
    chk(STATUS_REG, 8'h92, "frozen field refused");
    cmd(swp_pkg::CMD_STATUS_CLEAR);
    hw_reset();
    chk(LOCK_BIT, 1'h0, "password mode locks");
    chk(PROT_MODE, swp_pkg::MODE_PASSWORD, "mode kept");
    cmd(swp_pkg::CMD_UNLOCK, 3'h0, ~KEY);
    chk(LOCK_BIT, 1'h0, "wrong key");
    cmd(swp_pkg::CMD_UNLOCK, 3'h0, KEY);
    chk(LOCK_BIT, 1'h1, "right key");
    sw_reset();
    chk(LOCK_BIT, 1'h1, "soft reset keeps lock");
    cmd(swp_pkg::CMD_LOCK_CLEAR);
    chk(LOCK_BIT, 1'h0, "relocked");
    results();
  end
endmodule
